// ### shared/dbalc_pkg.sv
package dbalc_pkg;
  localparam int NUM_PIPES       = 4;
  localparam int PLANES_PER_PIPE = 4;
  localparam int NUM_PLANES      = NUM_PIPES * PLANES_PER_PIPE;
  localparam int BLK_W           = 11;
  localparam int LINES_PER_BLOCK = 8;
  localparam logic [BLK_W-1:0] SLICE1_FIRST = 11'h000;
  localparam logic [BLK_W-1:0] SLICE1_LAST  = 11'h3FF;
  localparam logic [BLK_W-1:0] SLICE2_FIRST = 11'h400;
  localparam logic [BLK_W-1:0] SLICE2_LAST  = 11'h7FF;
  localparam int PIPE_A = 0;
  localparam int PIPE_B = 1;
  localparam int PIPE_C = 2;
  localparam int PIPE_D = 3;
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_SEL    = 4'h2;
  localparam logic [3:0] ADDR_RANGE  = 4'h3;
  localparam logic [3:0] ADDR_ENABLE = 4'h4;
  localparam logic [3:0] ADDR_PSLICE = 4'h5;
  localparam int CTRL_S2_POS   = 0;
  localparam int STAT_OVL_POS  = 0;
  localparam int STAT_SLC_POS  = 1;
  localparam int STAT_S2_POS   = 2;
  localparam int STAT_BUSY_POS = 3;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  typedef struct packed {
    logic [BLK_W-1:0] last;
    logic [BLK_W-1:0] first;
  } dbalc_range_type;

  typedef enum logic [1:0] {
    DBALC_IDLE = 2'b00,
    DBALC_SCAN = 2'b01,
    DBALC_DONE = 2'b11
  } dbalc_state_type;
endpackage

// ### hdl/dbalc_allocator.sv
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/1ps
// Overview of operation
// - each plane owns one contiguous range, first and last block registers.
// - slice one spans blocks 0..1023, slice two 1024..2047.
// - one block holds eight cache lines of plane data.
// - a plane allowed both slices may straddle the slice boundary.
module dbalc_allocator #(
  parameter int NUM_PLANES = dbalc_pkg::NUM_PLANES
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [31:0]      rdata,
  output logic [NUM_PLANES*2*dbalc_pkg::BLK_W-1:0] plane_ranges,
  output logic [NUM_PLANES-1:0] plane_enables,
  output logic             first_buffer_slice,
  output logic             second_buffer_slice,
  output logic             alloc_error
);
  localparam int W = dbalc_pkg::BLK_W;
  localparam int IW = $clog2(NUM_PLANES);

  initial begin
    if (NUM_PLANES < 2 || NUM_PLANES > 32) begin
      $error("NUM_PLANES out of range");
    end
  end

  dbalc_pkg::dbalc_range_type range_q [NUM_PLANES];
  logic [NUM_PLANES-1:0]      en_q;
  logic [NUM_PLANES-1:0]      pslice_q;
  logic [31:0]                ctrl_q;
  logic [IW-1:0]              sel_q;
  dbalc_pkg::dbalc_state_type state;
  logic [IW-1:0]              i_q;
  logic [IW-1:0]              j_q;
  logic                       ovl_q;
  logic                       slc_q;
  logic                       ovl_sticky;
  logic                       slc_sticky;
  logic                       recheck;

  function automatic logic in_slice2(input dbalc_pkg::dbalc_range_type r);
    in_slice2 = (r.last >= dbalc_pkg::SLICE2_FIRST);
  endfunction

  function automatic logic in_slice1(input dbalc_pkg::dbalc_range_type r);
    in_slice1 = (r.first <= dbalc_pkg::SLICE1_LAST);
  endfunction

  // register writes; any enable change schedules a new check
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q   <= dbalc_pkg::CTRL_RESET;
      sel_q    <= '0;
      en_q     <= '0;
      pslice_q <= '0;
      recheck  <= 1'b0;
      for (int k = 0; k < NUM_PLANES; k++) begin
        range_q[k] <= '0;
      end
    end else begin
      recheck <= 1'b0;
      if (wr) begin
        case (addr)
          dbalc_pkg::ADDR_CTRL: begin
            ctrl_q  <= wdata;
            recheck <= 1'b1;
          end
          dbalc_pkg::ADDR_SEL: begin
            sel_q <= wdata[IW-1:0];
          end
          dbalc_pkg::ADDR_RANGE: begin
            range_q[sel_q] <= {wdata[16+W-1:16], wdata[W-1:0]};
            recheck <= 1'b1;
          end
          dbalc_pkg::ADDR_ENABLE: begin
            en_q    <= wdata[NUM_PLANES-1:0];
            recheck <= 1'b1;
          end
          dbalc_pkg::ADDR_PSLICE: begin
            pslice_q <= wdata[NUM_PLANES-1:0];
            recheck  <= 1'b1;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // pairwise scan over enabled planes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= dbalc_pkg::DBALC_IDLE;
      i_q   <= '0;
      j_q   <= '0;
      ovl_q <= 1'b0;
      slc_q <= 1'b0;
      ovl_sticky <= 1'b0;
      slc_sticky <= 1'b0;
    end else begin
      case (state)
        dbalc_pkg::DBALC_IDLE: begin
          if (recheck) begin
            state <= dbalc_pkg::DBALC_SCAN;
            i_q   <= '0;
            j_q   <= IW'(1);
            ovl_q <= 1'b0;
            slc_q <= 1'b0;
          end
        end
        dbalc_pkg::DBALC_SCAN: begin
          // a change during the scan restarts it so it is never missed
          if (recheck) begin
            i_q   <= '0;
            j_q   <= IW'(1);
            ovl_q <= 1'b0;
            slc_q <= 1'b0;
          end else begin
            if (en_q[i_q] && en_q[j_q] &&
                range_q[i_q].first <= range_q[j_q].last &&
                range_q[j_q].first <= range_q[i_q].last) begin
              ovl_q <= 1'b1;
            end
            if ((en_q[i_q] && in_slice2(range_q[i_q]) ||
                 en_q[j_q] && in_slice2(range_q[j_q])) &&
                !ctrl_q[dbalc_pkg::CTRL_S2_POS]) begin
              slc_q <= 1'b1;
            end
            if (en_q[i_q] && !pslice_q[i_q] && in_slice1(range_q[i_q]) &&
                in_slice2(range_q[i_q])) begin
              slc_q <= 1'b1;
            end
            if (en_q[j_q] && !pslice_q[j_q] && in_slice1(range_q[j_q]) &&
                in_slice2(range_q[j_q])) begin
              slc_q <= 1'b1;
            end
            if (j_q == IW'(NUM_PLANES-1)) begin
              if (i_q == IW'(NUM_PLANES-2)) begin
                state <= dbalc_pkg::DBALC_DONE;
              end else begin
                i_q <= i_q + IW'(1);
                j_q <= i_q + IW'(2);
              end
            end else begin
              j_q <= j_q + IW'(1);
            end
          end
        end
        dbalc_pkg::DBALC_DONE: begin
          ovl_sticky <= ovl_q;
          slc_sticky <= slc_q;
          state <= recheck ? dbalc_pkg::DBALC_SCAN
                           : dbalc_pkg::DBALC_IDLE;
          i_q   <= '0;
          j_q   <= IW'(1);
          ovl_q <= 1'b0;
          slc_q <= 1'b0;
        end
        default: begin
          state <= dbalc_pkg::DBALC_IDLE;
        end
      endcase
    end
  end

  // outputs to fetch engines and slice power
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      plane_ranges        <= '0;
      plane_enables       <= '0;
      first_buffer_slice  <= 1'b0;
      second_buffer_slice <= 1'b0;
      alloc_error         <= 1'b0;
    end else begin
      for (int k = 0; k < NUM_PLANES; k++) begin
        plane_ranges[k*2*W +: 2*W] <= range_q[k];
      end
      plane_enables       <= en_q;
      first_buffer_slice  <= 1'b1;
      second_buffer_slice <= ctrl_q[dbalc_pkg::CTRL_S2_POS];
      alloc_error         <= ovl_sticky | slc_sticky;
    end
  end

  // read port, data one cycle after strobe
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= '0;
    end else begin
      rdata <= '0;
      if (rd) begin
        case (addr)
          dbalc_pkg::ADDR_CTRL:   rdata <= ctrl_q;
          dbalc_pkg::ADDR_STATUS: begin
            rdata[dbalc_pkg::STAT_OVL_POS]  <= ovl_sticky;
            rdata[dbalc_pkg::STAT_SLC_POS]  <= slc_sticky;
            rdata[dbalc_pkg::STAT_S2_POS]   <= second_buffer_slice;
            rdata[dbalc_pkg::STAT_BUSY_POS] <=
              (state != dbalc_pkg::DBALC_IDLE);
          end
          dbalc_pkg::ADDR_SEL:    rdata[IW-1:0] <= sel_q;
          dbalc_pkg::ADDR_RANGE: begin
            rdata[W-1:0]     <= range_q[sel_q].first;
            rdata[16+W-1:16] <= range_q[sel_q].last;
          end
          dbalc_pkg::ADDR_ENABLE: rdata[NUM_PLANES-1:0] <= en_q;
          dbalc_pkg::ADDR_PSLICE: rdata[NUM_PLANES-1:0] <= pslice_q;
          default: rdata <= '0;
        endcase
      end
    end
  end
endmodule

// ### verification/dbalc_alloc_monitor.sv
`timescale 1ns/1ps
module dbalc_alloc_monitor #(parameter int NUM_PLANES = 16) (
  input wire logic                     clk,
  input wire logic                     reset_n,
  input wire logic [3:0]               addr,
  input wire logic [31:0]              wdata,
  input wire logic                     wr,
  input wire logic                     rd,
  input wire logic [31:0]              rdata,
  input wire logic [NUM_PLANES*22-1:0] plane_ranges,
  input wire logic [NUM_PLANES-1:0]    plane_enables,
  input wire logic                     first_buffer_slice,
  input wire logic                     second_buffer_slice,
  input wire logic                     alloc_error
);
  logic [3:0] sel_q;
  logic       viol;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) sel_q <= 4'h0;
    else if (wr && addr == dbalc_pkg::ADDR_SEL) sel_q <= wdata[3:0];
  end
  // an enabled range reaching into slice two while it is off
  always_comb begin
    viol = 1'b0;
    for (int k = 0; k < NUM_PLANES; k++) begin
      if (plane_enables[k] && plane_ranges[k*22+21]) viol = !second_buffer_slice;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  chk_slice_one_on: assert property ($past(reset_n) |-> first_buffer_slice)
    else $error("first slice off");
  chk_slice_two_ctl: assert property (wr && addr == dbalc_pkg::ADDR_CTRL |->
    ##2 second_buffer_slice == $past(wdata[0], 2))
    else $error("second slice wrong");
  chk_range_load: assert property (wr && addr == dbalc_pkg::ADDR_RANGE |->
    ##2 plane_ranges[$past(sel_q, 2)*22 +: 22] ==
    {$past(wdata[26:16], 2), $past(wdata[10:0], 2)})
    else $error("range not loaded");
  chk_enable_load: assert property (wr && addr == dbalc_pkg::ADDR_ENABLE |->
    ##2 plane_enables == $past(wdata[NUM_PLANES-1:0], 2))
    else $error("enables wrong");
  chk_read_idle: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data outside slot");
  chk_slice_err: assert property (viol [*8] |-> ##[0:200] (alloc_error || !viol))
    else $error("slice violation not flagged");
endmodule
bind dbalc_allocator dbalc_alloc_monitor #(.NUM_PLANES(NUM_PLANES)) mon (
  .clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .plane_ranges(plane_ranges), .plane_enables(plane_enables),
  .first_buffer_slice(first_buffer_slice),
  .second_buffer_slice(second_buffer_slice), .alloc_error(alloc_error));

// ### verification/dbalc_fetch_model.sv
`timescale 1ns/1ps
module dbalc_fetch_model #(parameter int NUM_PLANES = 16) (
  input wire logic [NUM_PLANES*22-1:0] plane_ranges,
  input wire logic [NUM_PLANES-1:0]    plane_enables,
  output logic [15:0]                  lines_held
);
  // cache lines held by the fetch engines of all enabled planes
  always_comb begin
    lines_held = 16'h0000;
    for (int k = 0; k < NUM_PLANES; k++) begin
      if (plane_enables[k]) begin
        lines_held += 16'(dbalc_pkg::LINES_PER_BLOCK *
          (plane_ranges[k*22+11 +: 11] - plane_ranges[k*22 +: 11] + 1));
      end
    end
  end
endmodule

// ### verification/display_buffer_block_allocator_bench.sv
`timescale 1ns/1ps
module display_buffer_block_allocator_bench;
  typedef struct packed {
    logic [10:0] first;
    logic [10:0] last;
    logic [1:0]  en;
    logic        s2;
    logic        ps;
    logic        err;
  } dbalc_row_type;
  logic        clk, reset_n, wr, rd, fbs, sbs, err;
  logic [3:0]  addr;
  logic [31:0] wdata, rdata, rv;
  logic [351:0] ranges;
  logic [15:0] enables, lines;
  int          miscompares, checked, e;
  // rows keep software's side
  // allocation flow is software's
  // rotation and reprogramming order
  dbalc_row_type rows [7] = '{
    '{11'h000, 11'h3FF, 2'h1, 1'h0, 1'h0, 1'h0},
    '{11'h000, 11'h400, 2'h1, 1'h0, 1'h0, 1'h1},
    '{11'h3E8, 11'h44C, 2'h1, 1'h1, 1'h0, 1'h1},
    '{11'h3E8, 11'h44C, 2'h1, 1'h1, 1'h1, 1'h0},
    '{11'h400, 11'h7FF, 2'h1, 1'h1, 1'h0, 1'h0},
    '{11'h008, 11'h064, 2'h3, 1'h1, 1'h0, 1'h0},
    '{11'h000, 11'h064, 2'h3, 1'h1, 1'h0, 1'h1}};
  dbalc_allocator #(.NUM_PLANES(16)) DUT (.clk(clk), .reset_n(reset_n),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .plane_ranges(ranges), .plane_enables(enables), .first_buffer_slice(fbs),
    .second_buffer_slice(sbs), .alloc_error(err));
  dbalc_fetch_model #(.NUM_PLANES(16)) fetch (.plane_ranges(ranges),
    .plane_enables(enables), .lines_held(lines));
  task automatic check(input string name, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  task automatic wait_idle();
    logic [31:0] s;
    s = 32'h8;
    for (int i = 0; i < 400 && s[3] !== 1'b0; i++) rd_reg(4'h1, s);
    if (s[3] !== 1'b0) miscompares++;
    repeat (3) @(posedge clk);
  endtask
  task automatic summarize();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (30000) @(posedge clk);
    miscompares++;
    summarize();
  end
  initial begin
    {reset_n, wr, rd, addr, wdata, miscompares, checked} = '0;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1 check("first_slice", {31'h0, fbs}, 32'h1);
    foreach (rows[i]) begin
      wr_reg(dbalc_pkg::ADDR_CTRL, {31'h0, rows[i].s2});
      wr_reg(dbalc_pkg::ADDR_SEL, 32'h0);
      wr_reg(dbalc_pkg::ADDR_PSLICE, {31'h0, rows[i].ps});
      wr_reg(dbalc_pkg::ADDR_RANGE, {5'h0, rows[i].last, 5'h0, rows[i].first});
      for (int j = 0; j < 2; j++) begin
        wr_reg(dbalc_pkg::ADDR_ENABLE, {30'h0, rows[i].en});
        wait_idle();
      end
      e = 8 * (rows[i].last - rows[i].first + 1 + rows[i].en[1]);
      check("range", ranges[21:0], {rows[i].last, rows[i].first});
      check("error", {31'h0, err}, {31'h0, rows[i].err});
      check("slice2", {31'h0, sbs}, {31'h0, rows[i].s2});
      check("lines", {16'h0, lines}, e);
      check("enables", {16'h0, enables}, {30'h0, rows[i].en});
      rd_reg(dbalc_pkg::ADDR_RANGE, rv);
      check("range_rd", rv, {5'h0, rows[i].last, 5'h0, rows[i].first});
      rd_reg(dbalc_pkg::ADDR_STATUS, rv);
      check("status", rv, {28'h0, 1'b0, rows[i].s2,
        rows[i].err && i != 6, rows[i].err && i == 6});
    end
    wr_reg(4'hF, 32'hFFFF_FFFF);
    rd_reg(4'hF, rv);
    check("unmapped", rv, 32'h0);
    wr_reg(dbalc_pkg::ADDR_CTRL, 32'h0);
    rd_reg(dbalc_pkg::ADDR_CTRL, rv);
    check("ctrl", rv, 32'h0);
    reset_n <= 1'b0;
    @(posedge clk);
    #1 check("reset", {13'h0, fbs, sbs, err, enables}, 32'h0);
    @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1 check("first_slice", {31'h0, fbs}, 32'h1);
    summarize();
  end
endmodule
